// *** hw/dtg_regs.svh ***
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: Included by bare name; definitions only
// Notes:   Counts are in command clocks unless named _PS
`ifndef DTG_REGS_SVH
`define DTG_REGS_SVH

// Register offsets (byte addresses)
`define DTG_OFF_CTRL    8'h00
`define DTG_OFF_START   8'h04
`define DTG_OFF_TXPR    8'h08
`define DTG_OFF_TXS     8'h0C
`define DTG_OFF_TMOD    8'h10
`define DTG_OFF_TRFC    8'h14
`define DTG_OFF_PL      8'h18
`define DTG_OFF_WL      8'h1C
`define DTG_OFF_CAL     8'h20
`define DTG_OFF_STATUS  8'h24
`define DTG_OFF_INFO    8'h28

// CTRL fields
`define DTG_CTRL_PRE2   0
`define DTG_CTRL_PAR    1
`define DTG_CTRL_DLLOFF 2
`define DTG_CTRL_BC4MR  3
// START fields (write-one pulses)
`define DTG_START_GEAR  0
`define DTG_START_LVLON 1
`define DTG_START_LVLOF 2
// STATUS fields
`define DTG_ST_DONE     0
`define DTG_ST_BUSY     1
`define DTG_ST_LVL      2
`define DTG_ST_REFBUSY  3
`define DTG_ST_HOT      4
`define DTG_ST_ODT      5
`define DTG_ST_FB       6

// Reset values
`define DTG_RST_TXPR    16'h0100
`define DTG_RST_TXS     16'h0100
`define DTG_RST_TMOD    16'h0018
`define DTG_RST_PL      8'h00
`define DTG_RST_WL      8'h09

// Fixed counts
`define DTG_ODT_L_1CK   6
`define DTG_ODT_L_2CK   7
`define DTG_ODT_S_1CK   4
`define DTG_ODT_S_2CK   5
`define DTG_LVL_EDGE    40
`define DTG_LVL_DRIVE   25
`define DTG_SYNC_EXTRA  4
`define DTG_WR_LONG     4
`define DTG_WR_SHORT    2
`define DTG_CAL_MIN_CK  3
`define DTG_CAL_MIN_PS  3748
`define DTG_SPD_ADJ     974
`define DTG_GRADE_FLOOR 1600

`endif

// *** hw/dtg_pkg.sv ***
// Purpose: Types and clock-count conversion helpers
// Assumes: Picosecond inputs are whole numbers
// Notes:   Functions run at elaboration only
`default_nettype none
package dtg_pkg;
    typedef enum logic [2:0] {
        S_IDLE  = 3'h0,
        S_WAIT  = 3'h1,
        S_SYNCW = 3'h2,
        S_CMDW  = 3'h3,
        S_DONE  = 3'h4
    } dtg_state_t;

    typedef enum logic [2:0] {
        CMD_NOP  = 3'h0,
        CMD_MRS  = 3'h1,
        CMD_SYNC = 3'h2,
        CMD_REF  = 3'h3,
        CMD_WR   = 3'h4
    } dtg_cmd_t;

    typedef enum logic [1:0] {
        ODT_NOWR = 2'h0,
        ODT_BL8  = 2'h1,
        ODT_BC4  = 2'h2
    } dtg_odt_t;

    // Presence-data limits: truncate(ps / tck + 0.974), integer math
    function automatic int nck_spd(input int ps, input int tck_ps);
        return (ps * 1000 + 974 * tck_ps) / (tck_ps * 1000);
    endfunction

    // Other limits: ceiling of time / period
    function automatic int nck_ceil(input int ps, input int tck_ps);
        return (ps + tck_ps - 1) / tck_ps;
    endfunction
endpackage
`default_nettype wire

// *** hw/dtg_countdown.sv ***
// Purpose: One countdown per timing constraint
// Assumes: Load value N counts clocks from the loading edge
// Notes:   o_done lets the dependent action happen N edges after load
`default_nettype none
module dtg_countdown #(
    parameter int W = 16
) (
    input  wire logic         i_clk,
    input  wire logic         i_reset_n,
    input  wire logic         i_load,
    input  wire logic [W-1:0] i_value,
    output logic              o_done
);
    logic [W-1:0] cnt_r;

    // Store N-1 so the action edge lands exactly N after the load
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cnt_r <= '0;
        end else if (i_load) begin
            cnt_r <= (i_value == '0) ? '0 : i_value - W'(1);
        end else if (cnt_r != '0) begin
            cnt_r <= cnt_r - W'(1);
        end
    end

    // Count only; a load term here would close a loop through the ready paths
    assign o_done = (cnt_r == '0);
endmodule
`default_nettype wire

// *** hw/dtg_ctrl.sv ***
// Function
// - Write with eight-beat burst: termination high 6 clocks, or 7 with long preamble.
// - No write or four-beat chop: termination high 4 clocks, or 5 with long preamble.
// - Leveling: first strobe rising edge no sooner than 40 clocks after mode write.
// - Leveling: strobe drive begins no sooner than 25 clocks after mode write.
// - Half-rate mode write waits the reset-exit delay after clock enable rises.
// - Half-rate enable waits the self-refresh exit delay after clock enable rises.
// - Sync pulse no sooner than mode update delay plus 4 after half-rate write.
// - First valid command waits mode update delay after the sync pulse.
// - Parity with loop off: every refresh busy time grows by parity latency.
// - Address latency is at least max of 3 clocks and 3.748 ns.
// - Time limits become whole clock counts by the defined rounding.
// - Below 1600 MT/s the 1600 grade limits apply.
// - Spread row accesses; repeated hits on one row are flagged.
// - Presence-data limits: truncate of ps over period plus 0.974.
// - Other limits: ceiling of time over period.
//
// Purpose: Host-side sequencer and timing guard for a DDR4 command port
// Assumes: Single clock equal to the memory command clock
// Notes:   Software sets delays through a plain register port
//
// The register offsets and the plain strobed port are this design's own decisions.
`include "dtg_regs.svh"
`default_nettype none
module dtg_ctrl #(
    parameter int CW        = 16,
    parameter int TCK_PS    = 10000,
    parameter int DATA_RATE = 200,
    parameter int TRFC_PS   = 260000,
    parameter int HOT_LIMIT = 64
) (
    input  wire logic        I_CLK,
    input  wire logic        I_RESET_N,
    input  wire logic [7:0]  I_ADDR,
    input  wire logic [31:0] I_WDATA,
    input  wire logic        I_WR,
    input  wire logic        I_RD,
    output logic      [31:0] O_RDATA,
    input  wire logic        I_ODT_REQ,
    input  wire logic [1:0]  I_ODT_KIND,
    output logic             O_ODT,
    input  wire logic        I_WR_REQ,
    input  wire logic [15:0] I_ROW,
    output logic             O_WR_READY,
    output logic             O_WR_START,
    input  wire logic        I_REF_REQ,
    output logic             O_REF_READY,
    input  wire logic        I_DQS_REQ,
    input  wire logic        I_DQ_FB,
    output logic             O_DQS_T,
    output logic             O_DQS_C,
    output logic             O_DQS_OE,
    output logic             O_CKE,
    output logic             O_CMD_VALID,
    output logic      [2:0]  O_CMD
);
    ////////////////////////////////////////////////////////////////////////////
    // Derived limits
    localparam int EFF_RATE = (DATA_RATE < `DTG_GRADE_FLOOR) ?
                              `DTG_GRADE_FLOOR : DATA_RATE;
    localparam int CAL_NS   = dtg_pkg::nck_ceil(`DTG_CAL_MIN_PS, TCK_PS);
    localparam int CAL_MIN  = (CAL_NS > `DTG_CAL_MIN_CK) ?
                              CAL_NS : `DTG_CAL_MIN_CK;
    localparam int TRFC_CK  = dtg_pkg::nck_spd(TRFC_PS, TCK_PS);
    localparam logic [7:0]    CAL_MIN_B = 8'(CAL_MIN);
    localparam logic [CW-1:0] TRFC_RST  = CW'(TRFC_CK);
    localparam logic [15:0]   RATE_B    = 16'(EFF_RATE);

    if (CW < 8 || CW > 32 || TCK_PS < 1 || HOT_LIMIT < 2 || HOT_LIMIT > 65535) begin : g_chk
        $error("dtg_ctrl: parameter out of range");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register file
    logic [3:0]    ctrl_r;
    logic [CW-1:0] txpr_r, txs_r, tmod_r, trfc_r;
    logic [7:0]    pl_r, wl_r, cal_r;
    logic          hot_r, fb_r, lvl_r, lvl_pend_r, lvl_dir_r;
    logic [31:0]   rdata_r;
    dtg_pkg::dtg_state_t state_r;

    logic wr_hit, start_gear, start_lvl_on, start_lvl_off, hot_set;
    assign wr_hit        = I_WR;
    assign start_gear    = wr_hit && I_ADDR == `DTG_OFF_START && I_WDATA[`DTG_START_GEAR];
    assign start_lvl_on  = wr_hit && I_ADDR == `DTG_OFF_START && I_WDATA[`DTG_START_LVLON];
    assign start_lvl_off = wr_hit && I_ADDR == `DTG_OFF_START && I_WDATA[`DTG_START_LVLOF];

    // Configuration writes
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            ctrl_r <= 4'h0;
            txpr_r <= CW'(`DTG_RST_TXPR);
            txs_r  <= CW'(`DTG_RST_TXS);
            tmod_r <= CW'(`DTG_RST_TMOD);
            trfc_r <= TRFC_RST;
            pl_r   <= `DTG_RST_PL;
            wl_r   <= `DTG_RST_WL;
            cal_r  <= CAL_MIN_B;
        end else if (wr_hit) begin
            case (I_ADDR)
                `DTG_OFF_CTRL: ctrl_r <= I_WDATA[3:0];
                `DTG_OFF_TXPR: txpr_r <= I_WDATA[CW-1:0];
                `DTG_OFF_TXS:  txs_r  <= I_WDATA[CW-1:0];
                `DTG_OFF_TMOD: tmod_r <= I_WDATA[CW-1:0];
                `DTG_OFF_TRFC: trfc_r <= I_WDATA[CW-1:0];
                `DTG_OFF_PL:   pl_r   <= I_WDATA[7:0];
                `DTG_OFF_WL:   wl_r   <= I_WDATA[7:0];
                // Values under the floor are raised to it
                `DTG_OFF_CAL:  cal_r  <= (I_WDATA[7:0] < CAL_MIN_B) ?
                                         CAL_MIN_B : I_WDATA[7:0];
                default:       ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Countdowns, one per constraint
    logic          ld_xpr, ld_sync, ld_cmd, ld_ref, ld_wr, ld_lvl, ld_odt;
    logic [CW-1:0] v_sync, v_cmd, v_ref, v_wr, v_odt;
    logic          dn_xpr, dn_xs, dn_sync, dn_cmd, dn_ref, dn_wr;
    logic          dn_l25, dn_l40, dn_odt;

    dtg_countdown #(.W(CW)) u_xpr (.i_clk(I_CLK), .i_reset_n(I_RESET_N), .i_load(ld_xpr),
        .i_value(txpr_r), .o_done(dn_xpr));
    dtg_countdown #(.W(CW)) u_xs (.i_clk(I_CLK), .i_reset_n(I_RESET_N), .i_load(ld_xpr),
        .i_value(txs_r), .o_done(dn_xs));
    dtg_countdown #(.W(CW)) u_sync (.i_clk(I_CLK), .i_reset_n(I_RESET_N), .i_load(ld_sync),
        .i_value(v_sync), .o_done(dn_sync));
    dtg_countdown #(.W(CW)) u_cmd (.i_clk(I_CLK), .i_reset_n(I_RESET_N), .i_load(ld_cmd),
        .i_value(v_cmd), .o_done(dn_cmd));
    dtg_countdown #(.W(CW)) u_ref (.i_clk(I_CLK), .i_reset_n(I_RESET_N), .i_load(ld_ref),
        .i_value(v_ref), .o_done(dn_ref));
    dtg_countdown #(.W(CW)) u_wr (.i_clk(I_CLK), .i_reset_n(I_RESET_N), .i_load(ld_wr),
        .i_value(v_wr), .o_done(dn_wr));
    dtg_countdown #(.W(CW)) u_l25 (.i_clk(I_CLK), .i_reset_n(I_RESET_N), .i_load(ld_lvl),
        .i_value(CW'(`DTG_LVL_DRIVE)), .o_done(dn_l25));
    dtg_countdown #(.W(CW)) u_l40 (.i_clk(I_CLK), .i_reset_n(I_RESET_N), .i_load(ld_lvl),
        .i_value(CW'(`DTG_LVL_EDGE)), .o_done(dn_l40));
    dtg_countdown #(.W(CW)) u_odt (.i_clk(I_CLK), .i_reset_n(I_RESET_N), .i_load(ld_odt),
        .i_value(v_odt), .o_done(dn_odt));

    ////////////////////////////////////////////////////////////////////////////
    // Command decisions
    logic seq_start, seq_mrs_go, seq_sync_go, lvl_go, ref_go, wr_go, base_ok;
    logic wr_pend_r, odt_r;

    assign seq_start   = start_gear && state_r == dtg_pkg::S_IDLE && !lvl_r && !lvl_pend_r;
    assign seq_mrs_go  = state_r == dtg_pkg::S_WAIT && dn_xpr && dn_xs;
    assign seq_sync_go = state_r == dtg_pkg::S_SYNCW && dn_sync;
    assign lvl_go      = lvl_pend_r;
    // User commands only once the half-rate entry has settled
    assign base_ok     = state_r == dtg_pkg::S_DONE && dn_cmd && !lvl_r && !lvl_pend_r;
    assign O_REF_READY = base_ok && dn_ref;
    assign O_WR_READY  = base_ok && dn_ref && dn_wr && !wr_pend_r && !I_REF_REQ;
    assign ref_go      = I_REF_REQ && O_REF_READY;
    assign wr_go       = I_WR_REQ && O_WR_READY;

    assign ld_xpr  = seq_start;
    assign ld_sync = seq_mrs_go;
    assign v_sync  = tmod_r + CW'(`DTG_SYNC_EXTRA);
    assign ld_cmd  = seq_sync_go;
    assign v_cmd   = tmod_r;
    assign ld_ref  = ref_go;
    // Parity plus loop-off lengthens every refresh
    assign v_ref   = (ctrl_r[`DTG_CTRL_PAR] && ctrl_r[`DTG_CTRL_DLLOFF]) ?
                     trfc_r + CW'(pl_r) : trfc_r;
    assign ld_wr   = wr_go;
    assign v_wr    = CW'(wl_r) + (ctrl_r[`DTG_CTRL_BC4MR] ?
                     CW'(`DTG_WR_SHORT) : CW'(`DTG_WR_LONG));
    assign ld_lvl  = lvl_go && lvl_dir_r;

    ////////////////////////////////////////////////////////////////////////////
    // Half-rate entry sequence
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            state_r <= dtg_pkg::S_IDLE;
        end else begin
            case (state_r)
                dtg_pkg::S_IDLE:  if (seq_start) state_r <= dtg_pkg::S_WAIT;
                dtg_pkg::S_WAIT:  if (seq_mrs_go) state_r <= dtg_pkg::S_SYNCW;
                dtg_pkg::S_SYNCW: if (seq_sync_go) state_r <= dtg_pkg::S_CMDW;
                dtg_pkg::S_CMDW:  if (dn_cmd) state_r <= dtg_pkg::S_DONE;
                dtg_pkg::S_DONE:  state_r <= dtg_pkg::S_DONE;
                default:          state_r <= dtg_pkg::S_IDLE;
            endcase
        end
    end

    // Clock enable rises when the sequence starts and stays high
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            O_CKE <= 1'b0;
        end else if (seq_start) begin
            O_CKE <= 1'b1;
        end
    end

    // Command bus; mode writes first, sync next, refresh before write
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            O_CMD_VALID <= 1'b0;
            O_CMD       <= dtg_pkg::CMD_NOP;
        end else begin
            O_CMD_VALID <= seq_mrs_go || seq_sync_go || lvl_go || ref_go || wr_go;
            if (seq_mrs_go || lvl_go) begin
                O_CMD <= dtg_pkg::CMD_MRS;
            end else if (seq_sync_go) begin
                O_CMD <= dtg_pkg::CMD_SYNC;
            end else if (ref_go) begin
                O_CMD <= dtg_pkg::CMD_REF;
            end else if (wr_go) begin
                O_CMD <= dtg_pkg::CMD_WR;
            end else begin
                O_CMD <= dtg_pkg::CMD_NOP;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Internal write start marker; one write tracked at a time
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            wr_pend_r  <= 1'b0;
            O_WR_START <= 1'b0;
        end else begin
            O_WR_START <= wr_pend_r && dn_wr;
            if (wr_go) begin
                wr_pend_r <= 1'b1;
            end else if (dn_wr) begin
                wr_pend_r <= 1'b0;
            end
        end
    end

    // Repeated hits on one row; set wins over a software clear
    logic [15:0] last_row_r, row_cnt_r;
    assign hot_set = wr_go && I_ROW == last_row_r && row_cnt_r == 16'(HOT_LIMIT - 2);
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            last_row_r <= 16'h0000;
            row_cnt_r  <= 16'h0000;
            hot_r      <= 1'b0;
        end else begin
            if (wr_go) begin
                last_row_r <= I_ROW;
                row_cnt_r  <= (I_ROW == last_row_r && row_cnt_r != 16'hFFFF) ?
                              row_cnt_r + 16'h0001 : 16'h0000;
            end
            if (hot_set) begin
                hot_r <= 1'b1;
            end else if (wr_hit && I_ADDR == `DTG_OFF_STATUS && I_WDATA[`DTG_ST_HOT]) begin
                hot_r <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Termination hold; a new request reloads the hold
    assign ld_odt = I_ODT_REQ;
    always_comb begin
        if (I_ODT_KIND == dtg_pkg::ODT_BL8) begin
            v_odt = ctrl_r[`DTG_CTRL_PRE2] ? CW'(`DTG_ODT_L_2CK) : CW'(`DTG_ODT_L_1CK);
        end else begin
            v_odt = ctrl_r[`DTG_CTRL_PRE2] ? CW'(`DTG_ODT_S_2CK) : CW'(`DTG_ODT_S_1CK);
        end
    end

    // High from the cycle after the request for exactly the hold count
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            odt_r <= 1'b0;
        end else if (I_ODT_REQ) begin
            odt_r <= 1'b1;
        end else if (dn_odt) begin
            odt_r <= 1'b0;
        end
    end
    assign O_ODT = odt_r;

    ////////////////////////////////////////////////////////////////////////////
    // Write leveling: mode write, then gated strobe drive and pulses
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            lvl_pend_r <= 1'b0;
            lvl_dir_r  <= 1'b0;
            lvl_r      <= 1'b0;
        end else begin
            if (lvl_go) begin
                lvl_pend_r <= 1'b0;
                lvl_r      <= lvl_dir_r;
            end else if (start_lvl_on && !lvl_r && !lvl_pend_r &&
                         (state_r == dtg_pkg::S_IDLE || state_r == dtg_pkg::S_DONE)) begin
                lvl_pend_r <= 1'b1;
                lvl_dir_r  <= 1'b1;
            end else if (start_lvl_off && lvl_r && !lvl_pend_r) begin
                lvl_pend_r <= 1'b1;
                lvl_dir_r  <= 1'b0;
            end
        end
    end

    // Drive only after the drive delay; first edge after the edge delay
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            O_DQS_OE <= 1'b0;
            O_DQS_T  <= 1'b0;
            O_DQS_C  <= 1'b0;
            fb_r     <= 1'b0;
        end else begin
            O_DQS_OE <= lvl_r && !lvl_pend_r && dn_l25;
            if (O_DQS_OE && dn_l40 && I_DQS_REQ && !O_DQS_T) begin
                O_DQS_T <= 1'b1;
                O_DQS_C <= 1'b0;
            end else begin
                O_DQS_T <= 1'b0;
                O_DQS_C <= lvl_r && !lvl_pend_r && dn_l25;
            end
            if (O_DQS_T) begin
                fb_r <= I_DQ_FB;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read port, data one cycle after the strobe
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            rdata_r <= 32'h0000_0000;
        end else if (I_RD) begin
            case (I_ADDR)
                `DTG_OFF_CTRL:   rdata_r <= {28'h0, ctrl_r};
                `DTG_OFF_TXPR:   rdata_r <= 32'(txpr_r);
                `DTG_OFF_TXS:    rdata_r <= 32'(txs_r);
                `DTG_OFF_TMOD:   rdata_r <= 32'(tmod_r);
                `DTG_OFF_TRFC:   rdata_r <= 32'(trfc_r);
                `DTG_OFF_PL:     rdata_r <= {24'h0, pl_r};
                `DTG_OFF_WL:     rdata_r <= {24'h0, wl_r};
                `DTG_OFF_CAL:    rdata_r <= {24'h0, cal_r};
                `DTG_OFF_STATUS: rdata_r <= {25'h0, fb_r, odt_r, hot_r, !dn_ref, lvl_r,
                                   state_r != dtg_pkg::S_IDLE && state_r != dtg_pkg::S_DONE,
                                   state_r == dtg_pkg::S_DONE};
                `DTG_OFF_INFO:   rdata_r <= {RATE_B, 8'h00, CAL_MIN_B};
                default:         rdata_r <= 32'h0000_0000;
            endcase
        end else begin
            rdata_r <= 32'h0000_0000;
        end
    end
    assign O_RDATA = rdata_r;
endmodule
`default_nettype wire

// *** verif/dtg_mem_model.sv ***
// Purpose: Memory-side model: internal write start and leveling feedback
// Assumes: Latency and chop mode are mirrored by the bench
// Notes:   Feedback toggles between strobes, like a released line
`default_nettype none
module dtg_mem_model (
    input  wire logic       i_clk,
    input  wire logic       i_reset_n,
    input  wire logic       i_cmd_valid,
    input  wire logic [2:0] i_cmd,
    input  wire logic [7:0] i_wl,
    input  wire logic       i_bc4mr,
    input  wire logic       i_dqs_t,
    output logic            o_wr_due,
    output logic            o_dq_fb
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [8:0] cnt_r;
    logic [1:0] seen_r;
    logic       tgl_r;
    ////////////////////////////////////////////////////////////////////////
    // Write start counted in whole clocks after the latency
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) cnt_r <= 9'h000;
        else if (i_cmd_valid && i_cmd == 3'h4)
            cnt_r <= {1'b0, i_wl} + (i_bc4mr ? 9'h002 : 9'h004);
        else if (cnt_r != 9'h000) cnt_r <= cnt_r - 9'h001;
    end
    assign o_wr_due = (cnt_r == 9'h001);
    // Feedback stands from the strobe cycle on, so the capture edge sees it
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) seen_r <= 2'h0;
        else seen_r <= {seen_r[0], i_dqs_t};
    end
    always_ff @(posedge i_clk) tgl_r <= (tgl_r === 1'b1) ? 1'b0 : 1'b1;
    assign o_dq_fb = (i_dqs_t || (|seen_r)) ? 1'b1 : tgl_r;
endmodule
`default_nettype wire

// *** verif/dtg_ctrl_chk.sv ***
// Purpose: Port-level timing checks; Assumes: one clock; Notes: bound below
`default_nettype none
module dtg_ctrl_chk (
    input wire logic       I_CLK,
    input wire logic       I_RESET_N,
    input wire logic       I_ODT_REQ,
    input wire logic [1:0] I_ODT_KIND,
    input wire logic       O_ODT,
    input wire logic       O_WR_START,
    input wire logic       O_REF_READY,
    input wire logic       O_WR_READY,
    input wire logic       O_DQS_T,
    input wire logic       O_DQS_C,
    input wire logic       O_DQS_OE,
    input wire logic       O_CMD_VALID,
    input wire logic [2:0] O_CMD
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] since_r;
    default clocking @(posedge I_CLK); endclocking
    default disable iff (!I_RESET_N);
    sequence s_wr; O_CMD_VALID && O_CMD == 3'h4; endsequence
    sequence s_sync; O_CMD_VALID && O_CMD == 3'h2; endsequence
    sequence s_ref; O_CMD_VALID && O_CMD == 3'h3; endsequence
    ////////////////////////////////////////////////////////////////////////
    // Clocks since last mode write, saturating so long gaps stay large
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) since_r <= 8'h00;
        else if (O_CMD_VALID && O_CMD == 3'h1) since_r <= 8'h01;
        else if (since_r != 8'hFF) since_r <= since_r + 8'h01;
    end
    AST_ODT_SHORT: assert property (I_ODT_REQ |=> O_ODT [*4])
        else $error("termination dropped early");
    AST_ODT_LONG: assert property (I_ODT_REQ && I_ODT_KIND == 2'h1 |=> O_ODT [*6])
        else $error("long termination dropped early");
    AST_LVL_OE: assert property ($rose(O_DQS_OE) |-> since_r >= 8'd25)
        else $error("strobe driven too soon");
    AST_LVL_EDGE: assert property ($rose(O_DQS_T) |-> since_r >= 8'd40)
        else $error("strobe edge too soon");
    AST_DQS_PAIR: assert property (O_DQS_T |-> O_DQS_OE && !O_DQS_C)
        else $error("strobe pair wrong");
    AST_SYNC_GAP: assert property (s_sync |-> since_r >= 8'd5)
        else $error("sync too soon");
    AST_WR_START: assert property (s_wr |-> ##[2:259] O_WR_START)
        else $error("no write start");
    AST_REF_BUSY: assert property (s_ref |-> !O_REF_READY && !O_WR_READY)
        else $error("ready during refresh");
endmodule
bind dtg_ctrl dtg_ctrl_chk u_chk (.I_CLK, .I_RESET_N, .I_ODT_REQ, .I_ODT_KIND, .O_ODT,
    .O_WR_START, .O_REF_READY, .O_WR_READY, .O_DQS_T, .O_DQS_C, .O_DQS_OE, .O_CMD_VALID, .O_CMD);
`default_nettype wire

// *** verif/tb_top.sv ***
// Purpose: Self-checking bench; Assumes: short delays; Notes: model mirrors WL
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst_n, wr = 0, rd = 0, oreq = 0, wreq = 0, rreq = 0, dreq = 0, bc4 = 0;
    logic [7:0]  addr = 0, wl = 8'h09;
    logic [31:0] wdata = 0, rdata;
    logic [1:0]  kind = 0;
    logic [15:0] row = 0;
    logic [11:0] rows [6] = '{12'h004, 12'h016, 12'h024, 12'h105, 12'h117, 12'h125};
    logic odt, wrdy, wst, rrdy, fb, dt, dc, doe, cke, cv, due;
    logic [2:0] cmd;
    int error_cnt = 0, compares = 0, cyc = 0, t_go, t_mrs, t_sync, t_rdy = 0, t_dqs = 0, n, i;
    dtg_ctrl #(.TCK_PS(10000), .DATA_RATE(200), .HOT_LIMIT(4)) dut (.I_CLK(clk), .I_RESET_N(rst_n),
        .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_ODT_REQ(oreq),
        .I_ODT_KIND(kind), .O_ODT(odt), .I_WR_REQ(wreq), .I_ROW(row), .O_WR_READY(wrdy),
        .O_WR_START(wst), .I_REF_REQ(rreq), .O_REF_READY(rrdy), .I_DQS_REQ(dreq), .I_DQ_FB(fb),
        .O_DQS_T(dt), .O_DQS_C(dc), .O_DQS_OE(doe), .O_CKE(cke), .O_CMD_VALID(cv), .O_CMD(cmd));
    dtg_mem_model mem (.i_clk(clk), .i_reset_n(rst_n), .i_cmd_valid(cv), .i_cmd(cmd), .i_wl(wl),
        .i_bc4mr(bc4), .i_dqs_t(dt), .o_wr_due(due), .o_dq_fb(fb));
    ////////////////////////////////////////////////////////////////////////
    // 100 MHz clock
    always #5 clk = ~clk;
    // Event stamps; old values read before the edge's updates land
    always @(posedge clk) begin
        cyc++;
        if (wr && addr == 8'h04 && wdata[0]) t_go = cyc;
        if (cv && cmd == 3'h1) t_mrs = cyc;
        if (cv && cmd == 3'h2) t_sync = cyc;
        if (rrdy === 1'b1 && t_rdy == 0) t_rdy = cyc;
        if (dt === 1'b1 && t_dqs == 0) t_dqs = cyc;
    end
    // Write start must match the memory's own moment every cycle
    always @(negedge clk) if (rst_n) chk({31'h0, wst}, {31'h0, due});
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1;
        @(posedge clk);
        wr <= 0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1;
        @(posedge clk);
        rd <= 0;
        @(negedge clk);
        chk(rdata & m, e);
    endtask
    task automatic pulse_cnt(input int sel, output int c);
        @(posedge clk);
        if (sel == 0) oreq <= 1;
        else rreq <= 1;
        @(posedge clk);
        oreq <= 0;
        rreq <= 0;
        c = 0;
        repeat (14) begin
            @(negedge clk);
            if ((sel == 0) ? (odt === 1'b1) : (rrdy === 1'b0)) c++;
        end
    endtask
    task automatic wr_run(input logic [15:0] r);
        @(posedge clk);
        row <= r;
        wreq <= 1;
        @(posedge clk);
        wreq <= 0;
        for (n = 0; n < 40 && wst !== 1'b1; n++) @(negedge clk);
    endtask
    task automatic finish_test();
        if (error_cnt == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Watchdog well beyond the expected run
    initial begin
        #200000;
        error_cnt++;
        finish_test();
    end
    // Main sequence: reset values, table of hold times, then hand-made cases
    initial begin
        rst_n <= 1'b0;
        repeat (8) @(posedge clk);
        rst_n <= 1;
        rchk(8'h14, 32'hFFFF, 32'd26);
        rchk(8'h28, 32'hFFFF00FF, {16'd1600, 16'h0003});
        wreg(8'h20, 32'h1);
        rchk(8'h20, 32'hFF, 32'h3);
        rchk(8'h3C, 32'hFFFFFFFF, 32'h0);
        for (i = 0; i < 6; i++) begin
            wreg(8'h00, {31'h0, rows[i][8]});
            kind <= rows[i][5:4];
            pulse_cnt(0, n);
            chk(n, rows[i][3:0]);
        end
        wreg(8'h08, 5); wreg(8'h0C, 5); wreg(8'h10, 3); wreg(8'h14, 4);
        chk({31'h0, cke}, 32'h0);
        wreg(8'h04, 32'h1);
        for (n = 0; n < 200 && t_rdy == 0; n++) @(negedge clk);
        chk({31'h0, (t_mrs - t_go) >= 5}, 32'h1);
        chk(t_sync - t_mrs, 7);
        chk(t_rdy - t_sync, 3);
        chk({31'h0, cke}, 32'h1);
        wreg(8'h18, 2); wreg(8'h00, 32'h6);
        pulse_cnt(1, n);
        chk(n, 4 + 2 - 1);
        wreg(8'h00, 32'h4);
        pulse_cnt(1, n);
        chk(n, 4 - 1);
        wr_run(16'h0011);
        wreg(8'h00, 32'h8); wreg(8'h1C, 2); bc4 <= 1; wl <= 8'h02;
        repeat (4) wr_run(16'h00AA);
        rchk(8'h24, 32'h10, 32'h10);
        wreg(8'h24, 32'h10);
        rchk(8'h24, 32'h10, 32'h0);
        wreg(8'h04, 32'h2);
        dreq <= 1;
        for (n = 0; n < 90 && t_dqs == 0; n++) @(negedge clk);
        chk({31'h0, (t_dqs - t_mrs) >= 40}, 32'h1);
        @(posedge clk) dreq <= 0;
        rchk(8'h24, 32'h44, 32'h44);
        wreg(8'h04, 32'h4);
        repeat (4) @(negedge clk);
        chk({31'h0, doe}, 32'h0);
        finish_test();
    end
endmodule
`default_nettype wire
